/* updown_counter_pkg.sv */
// package: constants and carrier types for the four-bit up/down counter
// assumes: one 100 MHz clock, asynchronous active-low reset, plain register port
package updown_counter_pkg;

	// ***************************************************
	// widths
	// ***************************************************
	localparam int COUNT_W = 4;
	localparam int ADDR_W  = 4;
	localparam int DATA_W  = 32;
	localparam int STAT_W  = 3;

	// ***************************************************
	// count values
	// ***************************************************
	localparam logic [COUNT_W-1:0] COUNT_RESET = 4'h0;
	localparam logic [COUNT_W-1:0] COUNT_MIN   = 4'h0;
	localparam logic [COUNT_W-1:0] COUNT_MAX   = 4'hf;
	localparam logic [COUNT_W-1:0] COUNT_STEP  = 4'h1;

	// ***************************************************
	// register offsets (byte addresses)
	// ***************************************************
	localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 4'h0;
	localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE = 4'h4;
	localparam logic [ADDR_W-1:0] OFS_IRQ_CLEAR  = 4'h8;
	localparam logic [ADDR_W-1:0] OFS_COUNT      = 4'hc;

	// ***************************************************
	// status bit positions and reset values
	// ***************************************************
	localparam int BIT_TERMINAL = 0;
	localparam int BIT_WRAP     = 1;
	localparam int BIT_LOADED   = 2;
	localparam logic [STAT_W-1:0] STATUS_RESET = 3'h0;
	localparam logic [STAT_W-1:0] ENABLE_RESET = 3'h0;
	localparam logic [DATA_W-1:0] RDATA_RESET  = 32'h0000_0000;

	// ***************************************************
	// carriers
	// ***************************************************
	typedef struct packed {
		logic               clear;
		logic               parallelLoadEnable;
		logic               countUp;
		logic               chainEnable_n;
		logic [COUNT_W-1:0] loadValue;
	} counter_ctrl_t;

	typedef struct packed {
		logic              wrStrobe;
		logic              rdStrobe;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wrData;
	} reg_req_t;

endpackage

/* count_step.sv */
// count_step: next binary value in the chosen direction, and terminal detect
// assumes: purely combinational, fed from the count register
`timescale 1ns/1ps
module count_step
	import updown_counter_pkg::*;
(
	// current state
	input  wire logic [updown_counter_pkg::COUNT_W-1:0] current,
	input  wire logic                                   countUp,
	// results
	output logic      [updown_counter_pkg::COUNT_W-1:0] next,
	output logic                                        atTerminal
);

	// ***************************************************
	// step and terminal
	// ***************************************************
	// natural 4-bit overflow gives the modulo-sixteen wrap
	wire [COUNT_W-1:0] upValue   = current + COUNT_STEP;
	wire [COUNT_W-1:0] downValue = current - COUNT_STEP;

	assign next       = countUp ? upValue : downValue;
	assign atTerminal = countUp ? (current == COUNT_MAX) : (current == COUNT_MIN);

endmodule

/* updown_counter.sv */
// updown_counter: four-bit synchronous up/down counter with cascade carry,
// asynchronous load and clear, and a small interrupt register block
// assumes: controls are synchronous to clock; the register master never waits
//
// Summary of operation
// - load high copies preset, clock ignored
// - clear high forces zero, clock ignored
// - chain enable active low; high holds count
// - step by one on rising edges only
// - direction high counts up, low down
// - count is binary, bit 0 least significant
// - terminal count output active low, synchronous
// - terminal low one cycle at 0/15
// - after load released, count resumes from preset
// - wraps modulo sixteen, cycles forever
//
// The implementer's own choices: strobed register access and the register addresses.
`timescale 1ns/1ps
module updown_counter
	import updown_counter_pkg::*;
(
	// clock and reset
	input  wire logic                                   clock,
	input  wire logic                                   arst_n,
	// counter controls
	input  wire updown_counter_pkg::counter_ctrl_t      ctrl,
	// counter outputs
	output logic      [updown_counter_pkg::COUNT_W-1:0] countValue,
	output logic                                        terminalCount_n,
	// register port
	input  wire updown_counter_pkg::reg_req_t           regReq,
	output logic      [updown_counter_pkg::DATA_W-1:0]  rdData,
	// interrupt
	output logic                                        irq
);

	// ***************************************************
	// declarations
	// ***************************************************
	logic [COUNT_W-1:0] countQ;
	logic [COUNT_W-1:0] countD;
	logic [COUNT_W-1:0] stepValue;
	logic               stepAtTerminal;
	logic [STAT_W-1:0]  statusQ;
	logic [STAT_W-1:0]  statusD;
	logic [STAT_W-1:0]  enableQ;
	logic [DATA_W-1:0]  rdDataQ;
	logic [DATA_W-1:0]  rdDataD;
	logic               loadSeenQ;

	// ***************************************************
	// step unit
	// ***************************************************
	count_step u_step
	(
		.current    (countQ),
		.countUp    (ctrl.countUp),
		.next       (stepValue),
		.atTerminal (stepAtTerminal)
	);

	// ***************************************************
	// control decode
	// ***************************************************
	// clear outranks load when both are high
	wire clearActive = ctrl.clear;
	wire loadActive  = ctrl.parallelLoadEnable & ~ctrl.clear;
	wire overridden  = clearActive | ctrl.parallelLoadEnable;
	wire chainActive = ~ctrl.chainEnable_n;
	wire countEnable = chainActive & ~overridden;

	// ***************************************************
	// count register
	// ***************************************************
	// load and clear act on the output at once, not at the next edge,
	// so the flop itself needs no data-driven asynchronous set
	assign countValue = clearActive ? COUNT_MIN
		: (loadActive ? ctrl.loadValue : countQ);

	assign countD = overridden ? countValue
		: (countEnable ? stepValue : countQ);

	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
			countQ <= COUNT_RESET;
		else
			countQ <= countD;
	end

	// ***************************************************
	// terminal count
	// ***************************************************
	// derived only from registered count and level controls: it changes
	// with the clock, and holds for the whole cycle the count sits at the end
	wire terminalHit = countEnable & stepAtTerminal;
	assign terminalCount_n = ~terminalHit;

	// ***************************************************
	// interrupt events
	// ***************************************************
	wire evTerminal = terminalHit;
	wire evWrap     = terminalHit;
	wire evLoaded   = ctrl.parallelLoadEnable & ~loadSeenQ;
	wire [STAT_W-1:0] events = {evLoaded, evWrap, evTerminal};

	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
			loadSeenQ <= 1'b0;
		else
			loadSeenQ <= ctrl.parallelLoadEnable;
	end

	// ***************************************************
	// register decode
	// ***************************************************
	wire selStatus = regReq.addr == OFS_IRQ_STATUS;
	wire selEnable = regReq.addr == OFS_IRQ_ENABLE;
	wire selClear  = regReq.addr == OFS_IRQ_CLEAR;
	wire selCount  = regReq.addr == OFS_COUNT;
	wire wrEnable  = regReq.wrStrobe & selEnable;
	wire wrClear   = regReq.wrStrobe & selClear;
	wire [STAT_W-1:0] clearMask = wrClear ? regReq.wrData[STAT_W-1:0] : STATUS_RESET;

	// an event in the clearing cycle survives the clear
	assign statusD = (statusQ & ~clearMask) | events;

	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			statusQ <= STATUS_RESET;
			enableQ <= ENABLE_RESET;
		end
		else
		begin
			statusQ <= statusD;
			if (wrEnable)
				enableQ <= regReq.wrData[STAT_W-1:0];
		end
	end

	assign irq = |(statusQ & enableQ);

	// ***************************************************
	// read path
	// ***************************************************
	// data stand only in the cycle after the strobe; unmapped reads give zero
	wire [DATA_W-1:0] statusWord = {{(DATA_W-STAT_W){1'b0}}, statusQ};
	wire [DATA_W-1:0] enableWord = {{(DATA_W-STAT_W){1'b0}}, enableQ};
	wire [DATA_W-1:0] countWord  = {{(DATA_W-COUNT_W){1'b0}}, countValue};

	assign rdDataD = !regReq.rdStrobe ? RDATA_RESET
		: selStatus ? statusWord
		: selEnable ? enableWord
		: selCount  ? countWord
		: RDATA_RESET;

	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
			rdDataQ <= RDATA_RESET;
		else
			rdDataQ <= rdDataD;
	end

	assign rdData = rdDataQ;

	// ***************************************************
	// assertions
	// ***************************************************
	property p_clear_zero;
		@(posedge clock) disable iff (!arst_n)
		ctrl.clear |-> (countValue == COUNT_MIN) ##1 (countQ == COUNT_MIN);
	endproperty
	a_clear_zero: assert property (p_clear_zero) else $error("clear did not force zero");

	property p_load_copy;
		@(posedge clock) disable iff (!arst_n)
		(ctrl.parallelLoadEnable && !ctrl.clear) |->
			(countValue == ctrl.loadValue) ##1 (countQ == $past(ctrl.loadValue));
	endproperty
	a_load_copy: assert property (p_load_copy) else $error("load did not copy preset");

	property p_hold_disabled;
		@(posedge clock) disable iff (!arst_n)
		(ctrl.chainEnable_n && !ctrl.clear && !ctrl.parallelLoadEnable) |=> (countQ == $past(countQ));
	endproperty
	a_hold_disabled: assert property (p_hold_disabled) else $error("count moved while disabled");

	property p_count_up;
		@(posedge clock) disable iff (!arst_n)
		(countEnable && ctrl.countUp) |=> (countQ == COUNT_W'($past(countQ) + COUNT_STEP));
	endproperty
	a_count_up: assert property (p_count_up) else $error("up count step wrong");

	property p_count_down;
		@(posedge clock) disable iff (!arst_n)
		(countEnable && !ctrl.countUp) |=> (countQ == COUNT_W'($past(countQ) - COUNT_STEP));
	endproperty
	a_count_down: assert property (p_count_down) else $error("down count step wrong");

	property p_wrap;
		@(posedge clock) disable iff (!arst_n)
		(countEnable && ctrl.countUp && countQ == COUNT_MAX) |=> (countQ == COUNT_MIN);
	endproperty
	a_wrap: assert property (p_wrap) else $error("count did not wrap");

	property p_terminal_low;
		@(posedge clock) disable iff (!arst_n)
		(countEnable && (ctrl.countUp ? countQ == COUNT_MAX : countQ == COUNT_MIN)) |-> !terminalCount_n;
	endproperty
	a_terminal_low: assert property (p_terminal_low) else $error("terminal count missed");

	property p_terminal_cause;
		@(posedge clock) disable iff (!arst_n)
		!terminalCount_n |-> (!ctrl.chainEnable_n && !ctrl.clear && !ctrl.parallelLoadEnable);
	endproperty
	a_terminal_cause: assert property (p_terminal_cause) else $error("terminal without chain enable");

	property p_terminal_one_cycle;
		@(posedge clock) disable iff (!arst_n)
		(!terminalCount_n && countEnable) |=> (terminalCount_n || !$stable(ctrl));
	endproperty
	a_terminal_one_cycle: assert property (p_terminal_one_cycle) else $error("terminal held past its cycle");

	sequence s_loaded_then_up;
		(ctrl.parallelLoadEnable && !ctrl.clear) ##1
		(!ctrl.parallelLoadEnable && !ctrl.clear && !ctrl.chainEnable_n && ctrl.countUp);
	endsequence

	property p_resume;
		@(posedge clock) disable iff (!arst_n)
		s_loaded_then_up |=> (countQ == COUNT_W'($past(ctrl.loadValue, 2) + COUNT_STEP));
	endproperty
	a_resume: assert property (p_resume) else $error("count did not resume from preset");

	property p_status_sticky;
		@(posedge clock) disable iff (!arst_n)
		evTerminal |=> statusQ[BIT_TERMINAL] ##1 (statusQ[BIT_TERMINAL] || $past(wrClear));
	endproperty
	a_status_sticky: assert property (p_status_sticky) else $error("terminal status not held");

	property p_read_window;
		@(posedge clock) disable iff (!arst_n)
		(!regReq.rdStrobe) |=> (rdData == RDATA_RESET);
	endproperty
	a_read_window: assert property (p_read_window) else $error("read data outside its cycle");

	property p_terminal_idle;
		@(posedge clock) disable iff (!arst_n)
		(ctrl.countUp ? countQ != COUNT_MAX : countQ != COUNT_MIN) |-> terminalCount_n;
	endproperty
	a_terminal_idle: assert property (p_terminal_idle) else $error("terminal away from end count");

	property p_down_wrap;
		@(posedge clock) disable iff (!arst_n)
		(countEnable && !ctrl.countUp && countQ == COUNT_MIN) |=> (countQ == COUNT_MAX);
	endproperty
	a_down_wrap: assert property (p_down_wrap) else $error("count did not wrap downward");

	property p_status_set;
		@(posedge clock) disable iff (!arst_n)
		evTerminal |=> (statusQ[BIT_TERMINAL] && statusQ[BIT_WRAP]);
	endproperty
	a_status_set: assert property (p_status_set) else $error("terminal event not recorded");

	property p_load_event;
		@(posedge clock) disable iff (!arst_n)
		$rose(ctrl.parallelLoadEnable) |=> statusQ[BIT_LOADED];
	endproperty
	a_load_event: assert property (p_load_event) else $error("load event not recorded");

	property p_clear_write;
		@(posedge clock) disable iff (!arst_n)
		(wrClear && events == STATUS_RESET) |=> ((statusQ & $past(clearMask)) == STATUS_RESET);
	endproperty
	a_clear_write: assert property (p_clear_write) else $error("status bit survived its clear");

	property p_enable_write;
		@(posedge clock) disable iff (!arst_n)
		wrEnable |=> (enableQ == $past(regReq.wrData[STAT_W-1:0]));
	endproperty
	a_enable_write: assert property (p_enable_write) else $error("enable write lost");

	property p_irq_masked;
		@(posedge clock) disable iff (!arst_n)
		(enableQ == ENABLE_RESET) |-> !irq;
	endproperty
	a_irq_masked: assert property (p_irq_masked) else $error("interrupt while all masked");

	property p_read_count;
		@(posedge clock) disable iff (!arst_n)
		(regReq.rdStrobe && selCount) |=> (rdData[COUNT_W-1:0] == $past(countValue));
	endproperty
	a_read_count: assert property (p_read_count) else $error("count read wrong");

	property p_read_status;
		@(posedge clock) disable iff (!arst_n)
		(regReq.rdStrobe && selStatus) |=> (rdData[STAT_W-1:0] == $past(statusQ));
	endproperty
	a_read_status: assert property (p_read_status) else $error("status read wrong");

	property p_read_enable;
		@(posedge clock) disable iff (!arst_n)
		(regReq.rdStrobe && selEnable) |=> (rdData[STAT_W-1:0] == $past(enableQ));
	endproperty
	a_read_enable: assert property (p_read_enable) else $error("enable read wrong");

endmodule

/* cascade_stage_model.sv */
// cascade_stage_model: behavioural higher stage of a counter cascade
// assumes: shares clock and reset with the stage under test
`timescale 1ns/1ps
module cascade_stage_model
	import updown_counter_pkg::*;
(
	// clock and reset
	input  wire logic                                   clock,
	input  wire logic                                   arst_n,
	// cascade input from the lower stage
	input  wire logic                                   carryIn_n,
	input  wire logic                                   countUp,
	// state
	output logic      [updown_counter_pkg::COUNT_W-1:0] count
);
	// steps only in the cycle the lower stage flags terminal, same clock
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
			count <= COUNT_RESET;
		else if (!carryIn_n)
			count <= countUp ? count + COUNT_STEP : count - COUNT_STEP;
	end
endmodule

/* test_four_bit_updown_counter.sv */
// test_four_bit_updown_counter: self-checking bench for the up/down counter
// assumes: 100 MHz clock, registers idle while the counter runs
`timescale 1ns/1ps
module test_four_bit_updown_counter;
	import updown_counter_pkg::*;
	logic                clock;
	logic                arst_n;
	counter_ctrl_t       ctrl;
	reg_req_t            regReq;
	logic [COUNT_W-1:0]  countValue;
	logic [COUNT_W-1:0]  stage2;
	logic                terminalCount_n;
	logic                irq;
	logic [DATA_W-1:0]   rdData;
	int                  failures;
	int                  n_compared;

	updown_counter updown_counter_i (.clock(clock), .arst_n(arst_n), .ctrl(ctrl),
		.countValue(countValue), .terminalCount_n(terminalCount_n), .regReq(regReq),
		.rdData(rdData), .irq(irq));
	cascade_stage_model cascade_stage_model_i (.clock(clock), .arst_n(arst_n),
		.carryIn_n(terminalCount_n), .countUp(ctrl.countUp), .count(stage2));

	// ***************************************************
	// plumbing
	// ***************************************************
	initial clock = 1'b0;
	always #5 clock = ~clock;

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp)
		begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask

	// code order: clear, load, up, chain enable low-active, preset[3:0]
	task automatic drive(input logic [7:0] c);
		@(posedge clock);
		ctrl <= counter_ctrl_t'(c);
		#1;
	endtask

	task automatic edges(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask

	task automatic regWrite(input logic [3:0] a, input logic [31:0] d);
		@(posedge clock);
		regReq <= '{1'b1, 1'b0, a, d};
		@(posedge clock);
		regReq <= '{1'b0, 1'b0, a, d};
		#1;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic regRead(input logic [3:0] a, input logic [31:0] exp, input string what);
		@(posedge clock);
		regReq <= '{1'b0, 1'b1, a, 32'h0};
		@(posedge clock);
		regReq <= '{1'b0, 1'b0, a, 32'h0};
		#1;
		chk(what, exp, rdData);
	endtask

	task automatic print_verdict;
		if (failures == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// ***************************************************
	// scenarios
	// ***************************************************
	task automatic resetValues;
		regRead(OFS_IRQ_STATUS, 32'h0, "status");
		regRead(OFS_IRQ_ENABLE, 32'h0, "enable");
		regRead(OFS_COUNT, 32'h0, "count reg");
		regRead(4'h2, 32'h0, "unmapped");
		chk("irq", 32'h0, 32'(irq));
	endtask

	task automatic loadAndWrap;
		drive(8'h6e);
		chk("preset shown", 32'he, 32'(countValue));
		chk("carry in load", 32'h1, 32'(terminalCount_n));
		edges(2);
		chk("edges ignored", 32'he, 32'(countValue));
		drive(8'h2e);
		chk("resume", 32'he, 32'(countValue));
		edges(1);
		chk("up step", 32'hf, 32'(countValue));
		chk("carry at 15", 32'h0, 32'(terminalCount_n));
		@(negedge clock);
		#1;
		chk("falling edge", 32'hf, 32'(countValue));
		chk("carry whole cycle", 32'h0, 32'(terminalCount_n));
		drive(8'h30);
		chk("wrap", 32'h0, 32'(countValue));
		chk("carry released", 32'h1, 32'(terminalCount_n));
		regRead(OFS_IRQ_STATUS, 32'h7, "status events");
	endtask

	task automatic irqFlow;
		regWrite(OFS_IRQ_CLEAR, 32'h7);
		regRead(OFS_IRQ_STATUS, 32'h0, "status cleared");
		regWrite(OFS_IRQ_ENABLE, 32'h1);
		chk("irq idle", 32'h0, 32'(irq));
		drive(8'h00);
		chk("carry at 0 down", 32'h0, 32'(terminalCount_n));
		drive(8'h10);
		chk("down wrap", 32'hf, 32'(countValue));
		chk("irq raised", 32'h1, 32'(irq));
		regRead(OFS_IRQ_ENABLE, 32'h1, "enable");
		regWrite(OFS_IRQ_ENABLE, 32'h0);
		chk("irq masked", 32'h0, 32'(irq));
		regRead(OFS_IRQ_STATUS, 32'h3, "status down");
		regWrite(OFS_COUNT, 32'h5);
		regRead(OFS_COUNT, 32'hf, "count read only");
		regWrite(OFS_IRQ_CLEAR, 32'h3);
		regRead(OFS_IRQ_STATUS, 32'h0, "status cleared");
	endtask

	task automatic holdAndClear;
		drive(8'h50);
		drive(8'h10);
		chk("no carry disabled", 32'h1, 32'(terminalCount_n));
		edges(3);
		chk("held", 32'h0, 32'(countValue));
		drive(8'h00);
		chk("carry enabled", 32'h0, 32'(terminalCount_n));
		drive(8'hc9);
		chk("clear over load", 32'h0, 32'(countValue));
		chk("carry in clear", 32'h1, 32'(terminalCount_n));
		edges(2);
		chk("clear holds", 32'h0, 32'(countValue));
	endtask

	// the upper stage must wrap inside four bits, so the sum is kept narrow
	task automatic fullCycle;
		logic [COUNT_W-1:0] s1;
		s1 = stage2 + COUNT_STEP;
		drive(8'h20);
		for (int i = 1; i <= 16; i++)
		begin
			edges(1);
			chk("cycle", 32'(i % 16), 32'(countValue));
		end
		chk("cascade stage", 32'(s1), 32'(stage2));
	endtask

	// divide by three: nonzero ratio loaded, counted down
	task automatic divideRatio;
		drive(8'h43);
		drive(8'h03);
		chk("ratio loaded", 32'h3, 32'(countValue));
		for (int i = 1; i <= 3; i++)
		begin
			edges(1);
			chk("ratio count", 32'(3 - i), 32'(countValue));
			chk("ratio carry", 32'(i != 3), 32'(terminalCount_n));
		end
	endtask

	// ***************************************************
	// sequence and watchdog
	// ***************************************************
	initial
	begin
		repeat (2000) @(posedge clock);
		failures++;
		$display("MISMATCH watchdog expected %h seen %h", 0, 1);
		print_verdict();
	end

	initial
	begin
		arst_n = 1'b0;
		ctrl = counter_ctrl_t'(8'h30);
		regReq = '0;
		failures = 0;
		n_compared = 0;
		repeat (5) @(posedge clock);
		arst_n <= 1'b1;
		#1;
		resetValues();
		loadAndWrap();
		irqFlow();
		holdAndClear();
		fullCycle();
		divideRatio();
		print_verdict();
	end
endmodule
